// File: hdl/cycle_timer.sv
// down counter that pulses when a loaded count runs out
module cycle_timer #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // control
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_busy,
  output logic o_done
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_load) begin
        cnt_r <= i_count;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (cnt_r <= W'(1)) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - W'(1);
        end
      end
    end
  end
endmodule

// File: hdl/nvm_array.sv
// 256 byte storage array with registered read data
module nvm_array #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock
  input wire logic i_clock,
  // access
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_re,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_re) begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule

// File: hdl/nvm_ctrl_pkg.sv
// constants for the data nvm write controller
package nvm_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_IRQ_CONTROL = 8'h0B;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] OFF_NVM_DATA = 8'h9A;
  localparam logic [7:0] OFF_NVM_ADDRESS = 8'h9B;
  localparam logic [7:0] OFF_NVM_CONTROL = 8'h9C;
  localparam logic [7:0] OFF_UNLOCK_KEY = 8'h9D;
  localparam int BIT_RD = 0;
  localparam int BIT_WR = 1;
  localparam int BIT_LATCH = 2;
  localparam int BIT_ABORT = 3;
  localparam int BIT_DONE = 7;
  localparam int BIT_GLOBAL_EN = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // bus cycles from first key write to write strobe set
  localparam int KEY_GAP_1 = 2;
  localparam int KEY_GAP_2 = 1;
  localparam int CLK_MHZ = 200;
  localparam int PUP_MS = 64;
  localparam int PUP_CYCLES = PUP_MS * 1000 * CLK_MHZ;
  localparam int WRITE_US = 4000;
  localparam int WRITE_CYCLES = WRITE_US * CLK_MHZ;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_KEY1 = 3'b010,
    ST_KEY2 = 3'b100
  } unlock_t;
endpackage

// File: hdl/nvm_write_ctrl.sv
// data nvm write controller with unlock sequence and register port
//
// What this block does
// - keys 55h then AAh, then write strobe
// - unlock steps must be back to back
// - write strobe ignored while latch clear
// - only software changes write enable latch
// - clearing latch never aborts running write
// - completion clears strobe, sets done flag
// - done flag sticks until software clears
// - done flag may raise gated interrupt
// - power-up clears write enable latch
// - power-up timer blocks writes
// - protect fuse does not block cpu access
// - non-power-on resets during write set abort flag
// - strobes set only; read self-clears
// - key register reads zero
// - address spans 256 byte locations
//
// Strobed register access is this design's own decision.
module nvm_write_ctrl
  import nvm_ctrl_pkg::*;
#(
  parameter int PUP_CNT = PUP_CYCLES,
  parameter int WRITE_CNT = WRITE_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // reset cause, same clock domain, level
  input wire logic i_power_on,
  input wire logic i_data_protect_fuse,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // status
  output logic o_irq,
  output logic o_write_busy
);
  import nvm_ctrl_pkg::*;

  if (PUP_CNT < 1 || WRITE_CNT < 2) begin : g_bad_cnt
    $error("timer counts too small");
  end

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] nvm_address_reg_r;
  logic [7:0] nvm_data_reg_r;
  logic [7:0] irq_control_reg_r;
  logic [7:0] periph_irq_flags_reg_r;
  logic [7:0] periph_irq_enable_reg_r;
  logic write_enable_latch_r;
  logic write_abort_flag_r;
  logic write_strobe_r;
  logic read_strobe_r;
  logic pup_busy;
  logic rel_pulse_r;
  logic write_done;
  logic write_start;
  logic arr_we_r;
  logic [7:0] arr_rdata;
  logic read_pend_r;
  unlock_t key_r;
  unlock_t key_nxt;
  logic [1:0] gap_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic w_ctl;
  logic w_key;
  assign w_ctl = i_wr && hit(i_addr, OFF_NVM_CONTROL);
  assign w_key = i_wr && hit(i_addr, OFF_UNLOCK_KEY);

  ////////////////////////////////////////////////////////////////////////
  // one pulse on the first edge after any reset release
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rel_pulse_r <= 1'b1;
    end else begin
      rel_pulse_r <= 1'b0;
    end
  end

  // power-up timer, started once after a power-on reset release
  logic pup_arm;
  assign pup_arm = rel_pulse_r && i_power_on;

  cycle_timer #(.W(32)) u_pup (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_load(pup_arm),
    .i_count(32'(PUP_CNT)),
    .o_busy(pup_busy),
    .o_done()
  );

  ////////////////////////////////////////////////////////////////////////
  // unlock sequencer; any stray bus write breaks the chain
  always_comb begin
    key_nxt = ST_IDLE;
    case (key_r)
      ST_IDLE: begin
        if (w_key && i_wdata == KEY_FIRST) begin
          key_nxt = ST_KEY1;
        end
      end
      ST_KEY1: begin
        if (gap_r < 2'(KEY_GAP_1 - KEY_GAP_2) && !(i_wr && !w_key)) begin
          if (w_key && i_wdata == KEY_SECOND
              && gap_r == 2'(KEY_GAP_1 - KEY_GAP_2 - 1)) begin
            key_nxt = ST_KEY2;
          end else if (!i_wr) begin
            key_nxt = ST_KEY1;
          end
        end
      end
      ST_KEY2: begin
        if (gap_r < 2'(KEY_GAP_2) && !i_wr) begin
          key_nxt = ST_KEY2;
        end
      end
      default: key_nxt = ST_IDLE;
    endcase
    if (key_r != ST_IDLE && w_key && i_wdata == KEY_FIRST
        && key_nxt == ST_IDLE) begin
      key_nxt = ST_KEY1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      key_r <= ST_IDLE;
      gap_r <= 2'd0;
    end else begin
      key_r <= key_nxt;
      // a repeated first key restarts the count
      gap_r <= (key_nxt != key_r || w_key) ? 2'd0 : gap_r + 2'd1;
    end
  end

  // fuse does not gate cpu writes
  assign write_start = w_ctl && i_wdata[BIT_WR] && key_r == ST_KEY2
                       && gap_r == 2'(KEY_GAP_2 - 1)
                       && write_enable_latch_r && !pup_busy
                       && !write_strobe_r;

  cycle_timer #(.W(32)) u_wtime (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_load(write_start),
    .i_count(32'(WRITE_CNT)),
    .o_busy(),
    .o_done(write_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // control register bits
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      write_enable_latch_r <= 1'b0;
    end else if (w_ctl) begin
      write_enable_latch_r <= i_wdata[BIT_LATCH];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      write_strobe_r <= 1'b0;
    end else if (write_start) begin
      write_strobe_r <= 1'b1;
    end else if (write_done) begin
      write_strobe_r <= 1'b0;
    end
  end

  // running write remembered; frozen while reset holds
  logic abort_seen_r;
  always_ff @(posedge i_clock) begin
    if (i_rst_n) begin
      abort_seen_r <= write_strobe_r;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      write_abort_flag_r <= 1'b0;
    end else if (rel_pulse_r && abort_seen_r && !i_power_on) begin
      write_abort_flag_r <= 1'b1;
    end else if (w_ctl) begin
      write_abort_flag_r <= i_wdata[BIT_ABORT];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      read_strobe_r <= 1'b0;
      read_pend_r <= 1'b0;
    end else begin
      read_strobe_r <= w_ctl && i_wdata[BIT_RD] && !write_strobe_r;
      read_pend_r <= read_strobe_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address, data and interrupt registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nvm_address_reg_r <= RESET_BYTE;
    end else if (i_wr && hit(i_addr, OFF_NVM_ADDRESS)) begin
      nvm_address_reg_r <= i_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nvm_data_reg_r <= RESET_BYTE;
    end else if (read_pend_r) begin
      nvm_data_reg_r <= arr_rdata;
    end else if (i_wr && hit(i_addr, OFF_NVM_DATA)) begin
      // write loads data register from bus
      nvm_data_reg_r <= i_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arr_we_r <= 1'b0;
    end else begin
      arr_we_r <= write_done;
    end
  end

  nvm_array #(.AW(ADDR_W), .DW(DATA_W)) u_array (
    .i_clock(i_clock),
    .i_we(arr_we_r),
    .i_addr(nvm_address_reg_r),
    .i_wdata(nvm_data_reg_r),
    .i_re(read_strobe_r),
    .o_rdata(arr_rdata)
  );

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      periph_irq_flags_reg_r <= RESET_BYTE;
    end else begin
      if (i_wr && hit(i_addr, OFF_IRQ_FLAGS)) begin
        periph_irq_flags_reg_r <= i_wdata;
      end
      if (arr_we_r) begin
        periph_irq_flags_reg_r[BIT_DONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      periph_irq_enable_reg_r <= RESET_BYTE;
      irq_control_reg_r <= RESET_BYTE;
    end else begin
      if (i_wr && hit(i_addr, OFF_IRQ_ENABLES)) begin
        periph_irq_enable_reg_r <= i_wdata;
      end
      if (i_wr && hit(i_addr, OFF_IRQ_CONTROL)) begin
        irq_control_reg_r <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
      o_write_busy <= 1'b0;
    end else begin
      o_irq <= periph_irq_flags_reg_r[BIT_DONE]
               && periph_irq_enable_reg_r[BIT_DONE]
               && irq_control_reg_r[BIT_GLOBAL_EN];
      o_write_busy <= write_strobe_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  logic [7:0] ctl_view;
  assign ctl_view = {4'h0, write_abort_flag_r, write_enable_latch_r,
                     write_strobe_r, read_strobe_r};

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= RESET_BYTE;
    end else if (i_rd) begin
      if (hit(i_addr, OFF_NVM_CONTROL)) begin
        o_rdata <= ctl_view;
      end else if (hit(i_addr, OFF_NVM_DATA)) begin
        o_rdata <= nvm_data_reg_r;
      end else if (hit(i_addr, OFF_NVM_ADDRESS)) begin
        o_rdata <= nvm_address_reg_r;
      end else if (hit(i_addr, OFF_IRQ_FLAGS)) begin
        o_rdata <= periph_irq_flags_reg_r;
      end else if (hit(i_addr, OFF_IRQ_ENABLES)) begin
        o_rdata <= periph_irq_enable_reg_r;
      end else if (hit(i_addr, OFF_IRQ_CONTROL)) begin
        o_rdata <= irq_control_reg_r;
      end else begin
        // key register and unmapped read zero
        o_rdata <= RESET_BYTE;
      end
    end else begin
      o_rdata <= RESET_BYTE;
    end
  end

  logic unused_ok;
  assign unused_ok = i_data_protect_fuse;
endmodule

// File: tb/nvm_write_ctrl_chk.sv
// port checker for the nvm write controller
module nvm_write_ctrl_chk
  import nvm_ctrl_pkg::*;
#(
  parameter int PUP_CNT = 20,
  parameter int WRITE_CNT = 10
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_power_on,
  input wire logic i_data_protect_fuse,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_write_busy
);
  int up_r;
  int run_r;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  //////////////////////////////
  // cycles since release, and length of the busy run
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_r <= 0;
      run_r <= 0;
    end else begin
      up_r <= (up_r < PUP_CNT) ? up_r + 1 : up_r;
      run_r <= o_write_busy ? run_r + 1 : 0;
    end
  end
  property p_key_zero;
    i_rd && i_addr == OFF_UNLOCK_KEY |=> o_rdata == 8'h00;
  endproperty
  a_key_zero: assert property (p_key_zero)
    else $error("key register read not zero");
  property p_rd_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_start_seq;
    $rose(o_write_busy) |->
      $past(i_wr && i_addr == OFF_NVM_CONTROL && i_wdata[BIT_WR], 2)
      && $past(i_wr && i_addr == OFF_UNLOCK_KEY && i_wdata == KEY_SECOND, 3)
      && $past(i_wr && i_addr == OFF_UNLOCK_KEY && i_wdata == KEY_FIRST, 4);
  endproperty
  a_start_seq: assert property (p_start_seq)
    else $error("write started without key sequence");
  property p_busy_len;
    $fell(o_write_busy) |-> run_r >= WRITE_CNT && run_r <= WRITE_CNT + 1;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write strobe length wrong");
  property p_pup;
    i_power_on && up_r < PUP_CNT |-> !$rose(o_write_busy);
  endproperty
  a_pup: assert property (p_pup)
    else $error("write started under power-up timer");
  property p_flag_clear;
    i_wr && i_addr == OFF_IRQ_FLAGS && !i_wdata[BIT_DONE] && !o_write_busy
      && !$past(o_write_busy) && !$past(o_write_busy, 2) |-> ##2 !o_irq;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("done flag not cleared by software");
  property p_en_clear;
    i_wr && i_addr == OFF_IRQ_ENABLES && !i_wdata[BIT_DONE] |-> ##2 !o_irq;
  endproperty
  a_en_clear: assert property (p_en_clear)
    else $error("masked interrupt still high");
  property p_latch_rb;
    i_wr && i_addr == OFF_NVM_CONTROL && i_wdata[BIT_LATCH] ##1
      i_rd && i_addr == OFF_NVM_CONTROL |=> o_rdata[BIT_LATCH];
  endproperty
  a_latch_rb: assert property (p_latch_rb)
    else $error("write enable latch lost");
  c_start: cover property ($rose(o_write_busy));
  c_irq: cover property ($rose(o_irq));
  c_key: cover property (i_rd && i_addr == OFF_UNLOCK_KEY);
endmodule
bind nvm_write_ctrl nvm_write_ctrl_chk #(
  .PUP_CNT(PUP_CNT), .WRITE_CNT(WRITE_CNT)
) u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_power_on(i_power_on),
  .i_data_protect_fuse(i_data_protect_fuse), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_irq(o_irq), .o_write_busy(o_write_busy));

// File: tb/tb.sv
// self-checking bench for the nvm write controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nvm_ctrl_pkg::*;
  logic i_clock, i_rst_n, i_power_on, i_data_protect_fuse, i_wr, i_rd;
  logic [7:0] i_addr, i_wdata, o_rdata, lf;
  logic o_irq, o_write_busy, rd_q;
  logic [7:0] exq[$];
  logic [7:0] regs[7] = '{OFF_IRQ_CONTROL, OFF_IRQ_FLAGS, OFF_IRQ_ENABLES,
    OFF_NVM_DATA, OFF_NVM_ADDRESS, OFF_NVM_CONTROL, OFF_UNLOCK_KEY};
  logic [23:0] ir[5] = '{24'h8C8000, 24'h0B8001, 24'h8C0000, 24'h8C8001,
    24'h0C0000};
  int n_mismatch = 0;
  int samples_checked = 0;
  nvm_write_ctrl #(.PUP_CNT(20), .WRITE_CNT(10)) dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_power_on(i_power_on),
    .i_data_protect_fuse(i_data_protect_fuse), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_write_busy(o_write_busy));
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  //////////////////////////////
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(input string nm, input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input logic w, r, input logic [7:0] a, d, e);
    @(posedge i_clock);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    if (r) exq.push_back(e);
  endtask
  task automatic wr(input logic [7:0] a, d);
    cyc(1'b1, 1'b0, a, d, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, e);
    cyc(1'b0, 1'b1, a, 8'h00, e);
  endtask
  task automatic idle();
    cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
  endtask
  // mode 1 leaves a gap in the keys, mode 2 swaps them
  task automatic nvm_write(input logic [7:0] a, d, lt, input int m);
    wr(OFF_NVM_ADDRESS, a);
    wr(OFF_NVM_DATA, d);
    wr(OFF_NVM_CONTROL, lt);
    rd(OFF_NVM_CONTROL, lt);
    wr(OFF_UNLOCK_KEY, m == 2 ? KEY_SECOND : KEY_FIRST);
    if (m == 1) idle();
    wr(OFF_UNLOCK_KEY, m == 2 ? KEY_FIRST : KEY_SECOND);
    wr(OFF_NVM_CONTROL, lt | 8'h02);
    idle();
  endtask
  // fixed window: a refused start shows no event to wait on
  task automatic settle(input logic exp_busy);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge i_clock);
      if (o_write_busy === 1'b1) seen = 1'b1;
    end
    check("started", {7'h00, seen}, {7'h00, exp_busy});
    check("busy", {7'h00, o_write_busy}, 8'h00);
  endtask
  always @(posedge i_clock) rd_q <= i_rd;
  always @(negedge i_clock)
    if (rd_q === 1'b1) check("rdata", o_rdata, exq.pop_front());
  //////////////////////////////
  initial begin
    i_rst_n = 1'b0;
    i_power_on = 1'b1;
    i_data_protect_fuse = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    lf = 8'h16;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    $display("end reset values");
    for (int i = 0; i < 4; i++) begin
      nvm_write(lf, nx(lf), i == 3 ? 8'h00 : 8'h04, i == 3 ? 0 : i);
      lf = nx(lf);
      settle(1'b0);
      rd(OFF_IRQ_FLAGS, 8'h00);
      rd(OFF_NVM_CONTROL, i == 3 ? 8'h00 : 8'h04);
    end
    $display("end refused starts");
    i_data_protect_fuse <= 1'b1;
    nvm_write(8'hFF, lf, 8'h04, 0);
    wr(OFF_NVM_CONTROL, 8'h00);
    idle();
    settle(1'b1);
    rd(OFF_IRQ_FLAGS, 8'h80);
    rd(OFF_NVM_CONTROL, 8'h00);
    rd(OFF_NVM_DATA, lf);
    wr(OFF_NVM_DATA, 8'h00);
    wr(OFF_NVM_CONTROL, 8'h01);
    idle();
    idle();
    rd(OFF_NVM_DATA, lf);
    $display("end good write");
    foreach (ir[i]) begin
      wr(ir[i][23:16], ir[i][15:8]);
      idle();
      idle();
      @(negedge i_clock);
      check("irq", {7'h00, o_irq}, ir[i][7:0]);
    end
    $display("end interrupt");
    nvm_write(8'h3C, nx(lf), 8'h04, 0);
    for (int i = 0; i < 9 && o_write_busy !== 1'b1; i++) @(negedge i_clock);
    if (o_write_busy !== 1'b1) begin
      n_mismatch++;
    end else begin
      @(posedge i_clock);
      i_power_on <= 1'b0;
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      rd(OFF_NVM_CONTROL, 8'h08);
      idle();
      idle();
    end
    $display("end abort");
    stop_test();
  end
  initial begin
    #20us;
    n_mismatch++;
    stop_test();
  end
endmodule
